// ===== inc/framer_defines.vh
// Purpose : Constants shared by the binary output packet framer and its helpers
// Assumes : Byte addresses on an APB bus with 32-bit data, one word per register
// Notes   : Size tables hold one byte per field, field 1 in the lowest byte
`ifndef FRAMER_DEFINES_VH
`define FRAMER_DEFINES_VH

// Packet constants
`define SYNC_VALUE        8'hFA
`define GROUP_USED_MASK   8'h3F
`define COMMON_FIELD_MASK 16'h7FFF
`define LAST_GROUP        3'd5
`define LAST_FIELD        4'hF
`define CRC_POLY          16'h1021
`define CRC_INIT          16'h0000

// Register byte addresses
`define APB_ADDR_W        8
`define REG_CTRL          8'h00
`define REG_GROUP_SELECT  8'h04
`define REG_STATUS        8'h08
`define REG_LAST_CRC      8'h0C
`define REG_FIELD_BASE    8'h10
`define FIELD_SPAN        8'h18
`define CTRL_START_BIT    0

// Per-group field size tables in bytes, field 1 at bits [7:0]
`define SIZE_GROUP1 128'h0008_0402_1C14_180C_0C18_0C10_0C08_0808
`define SIZE_GROUP2 128'h0000_0000_0000_0000_0408_0808_0208_0808
`define SIZE_GROUP3 128'h0000_0028_020C_0C0C_0C10_0404_0C0C_0C02
`define SIZE_GROUP4 128'h0000_0020_0404_0C0C_0C18_1801_0102_0808
`define SIZE_GROUP5 128'h0000_0000_181C_0C0C_0C0C_0C0C_2410_0C02
`define SIZE_GROUP6 128'h0000_0040_4404_040C_0C0C_0C0C_0C18_1802

`endif

// ===== design/byte_fifo.v
// Purpose : Small synchronous FIFO with valid and ready on both sides
// Assumes : One clock, asynchronous active-low reset
// Notes   : Full and empty come from an occupancy count, so no slot is wasted
`timescale 1ns/100ps
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter PTR_W = 2
) (
   input  wire             mclk,
   input  wire             resetn,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
   reg [PTR_W-1:0] wr_ptr;          // Next slot to fill
   reg [PTR_W-1:0] rd_ptr;          // Oldest word
   reg [PTR_W:0]   count;           // Words held

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   assign in_ready  = (count != DEPTH[PTR_W:0]);
   assign out_valid = (count != {(PTR_W+1){1'b0}});
   assign out_data  = mem[rd_ptr];

   // Pointer wrap must handle depths that are not a power of two
   function [PTR_W-1:0] bump;
      input [PTR_W-1:0] p;
      begin
         if (p == DEPTH[PTR_W-1:0] - 1'b1)
            bump = {PTR_W{1'b0}};
         else
            bump = p + 1'b1;
      end
   endfunction

   // Storage is written only, never reset
   always @(posedge mclk) begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   // Pointers and occupancy
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= {PTR_W{1'b0}};
         rd_ptr <= {PTR_W{1'b0}};
         count  <= {(PTR_W+1){1'b0}};
      end else begin
         if (push)
            wr_ptr <= bump(wr_ptr);
         if (pop)
            rd_ptr <= bump(rd_ptr);
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule // byte_fifo

// ===== design/field_size_lookup.v
// Purpose : Fixed payload size of one output field
// Assumes : Group index 0..5, field index 0..15
// Notes   : Unused fields and groups outside the table report zero bytes
`timescale 1ns/100ps
`include "framer_defines.vh"
module field_size_lookup (
   input  wire [2:0] group_idx,
   input  wire [3:0] field_idx,
   output reg  [7:0] field_bytes
);
   reg [127:0] row; // Size row of the chosen group

   // Pick the group row, then the byte of the field
   always @* begin
      case (group_idx)
         3'd0:    row = `SIZE_GROUP1;
         3'd1:    row = `SIZE_GROUP2;
         3'd2:    row = `SIZE_GROUP3;
         3'd3:    row = `SIZE_GROUP4;
         3'd4:    row = `SIZE_GROUP5;
         3'd5:    row = `SIZE_GROUP6;
         default: row = 128'h0;
      endcase
      field_bytes = row[{field_idx, 3'b000} +: 8];
   end
endmodule // field_size_lookup

// ===== design/packet_framer.v
// Purpose : Builds binary output packets into a byte stream, set up over APB
// Assumes : Payload bytes arrive in packet order, multi-byte values LSB first
// Notes   : Header and selects are snapshot at start, so APB writes mid-packet are safe
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "framer_defines.vh"
module packet_framer #(
   parameter FIFO_DEPTH = 4,
   parameter FIFO_PTR_W = 2
) (
   input  wire                   mclk,
   input  wire                   resetn,
   input  wire [`APB_ADDR_W-1:0] paddr,
   input  wire                   psel,
   input  wire                   penable,
   input  wire                   pwrite,
   input  wire [31:0]            pwdata,
   output reg  [31:0]            prdata,
   output wire                   pready,
   output wire                   pslverr,
   input  wire [7:0]             src_data,
   input  wire                   src_valid,
   output reg                    src_ready,
   output wire [7:0]             tx_data,
   output wire                   tx_valid,
   input  wire                   tx_ready,
   output wire                   frame_busy
);
   // State codes
   localparam ST_IDLE   = 3'd0;
   localparam ST_SYNC   = 3'd1;
   localparam ST_GROUPS = 3'd2;
   localparam ST_FSEL   = 3'd3;
   localparam ST_SCAN   = 3'd4;
   localparam ST_PAY    = 3'd5;
   localparam ST_CRC_HI = 3'd6;
   localparam ST_CRC_LO = 3'd7;

   reg  [2:0]  state;            // Framer state
   reg  [7:0]  group_sel;        // Software group select
   reg  [15:0] field_sel [0:5];  // Software field selects
   reg  [7:0]  group_live;       // Group select of the packet in flight
   reg  [15:0] field_live [0:5]; // Field selects of the packet in flight
   reg  [2:0]  grp_ptr;          // Group being walked
   reg  [3:0]  fld_ptr;          // Field being walked
   reg         hi_phase;         // Second byte of a field word
   reg  [7:0]  byte_left;        // Bytes left in the current field
   reg  [15:0] crc;              // Running CRC of the packet
   reg  [15:0] last_crc;         // CRC of the last finished packet
   reg  [15:0] packet_count;     // Finished packets
   reg  [7:0]  fifo_in_data;     // Byte offered to the FIFO
   reg         fifo_in_valid;    // Byte offered this cycle
   reg  [31:0] next_prdata;      // Read data for the setup cycle
   wire        fifo_in_ready;    // FIFO has room
   wire [7:0]  field_bytes;      // Size of the field under the pointer
   wire        take;             // Byte accepted by the FIFO
   wire [15:0] cur_field;        // Field word of the group under the pointer
   wire        last_pos;         // Pointer on the last table entry
   wire [2:0]  step_grp;         // Group after one step
   wire [3:0]  step_fld;         // Field after one step
   wire        setup;            // APB setup cycle
   wire        access;           // APB access cycle
   wire [7:0]  field_off;        // Offset into the field select block
   wire        field_hit;        // Address falls on a field select
   wire [2:0]  field_idx;        // Which field select
   wire        addr_ok;          // Address is mapped
   wire        start_req;        // Software start request
   integer     i;                // Loop index of the register process
   integer     j;                // Loop index of the sequencer, kept apart so each has one driver

   // One CRC-CCITT step, MSB first, so appending the CRC MSB first gives zero
   function [15:0] crc_step;
      input [15:0] c;
      input [7:0]  b;
      integer      k;
      reg   [15:0] t;
      begin
         t = c ^ {b, 8'h00};
         for (k = 0; k < 8; k = k + 1) begin
            if (t[15])
               t = {t[14:0], 1'b0} ^ `CRC_POLY;
            else
               t = {t[14:0], 1'b0};
         end
         crc_step = t;
      end
   endfunction

   // Number of active groups
   function [3:0] popcount;
      input [7:0] v;
      integer     k;
      begin
         popcount = 4'd0;
         for (k = 0; k < 8; k = k + 1)
            popcount = popcount + {3'd0, v[k]};
      end
   endfunction

   field_size_lookup u_size (
      .group_idx   (grp_ptr),
      .field_idx   (fld_ptr),
      .field_bytes (field_bytes)
   );

   // Output buffer; its ready stalls the framer when the link side is slow
   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH),
      .PTR_W (FIFO_PTR_W)
   ) u_fifo (
      .mclk      (mclk),
      .resetn    (resetn),
      .in_data   (fifo_in_data),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .out_data  (tx_data),
      .out_valid (tx_valid),
      .out_ready (tx_ready)
   );

   assign take       = fifo_in_valid & fifo_in_ready;
   assign cur_field  = field_live[grp_ptr];
   assign last_pos   = (grp_ptr == `LAST_GROUP) && (fld_ptr == `LAST_FIELD);
   assign step_fld   = fld_ptr + 4'd1;
   assign step_grp   = (fld_ptr == `LAST_FIELD) ? grp_ptr + 3'd1 : grp_ptr;
   assign frame_busy = (state != ST_IDLE);

   // APB decode; the slave never waits
   assign setup     = psel & ~penable;
   assign access    = psel & penable;
   assign field_off = paddr - `REG_FIELD_BASE;
   assign field_hit = (field_off < `FIELD_SPAN) && (field_off[1:0] == 2'b00);
   assign field_idx = field_off[4:2];
   assign addr_ok   = field_hit || (paddr == `REG_CTRL) || (paddr == `REG_GROUP_SELECT) ||
                      (paddr == `REG_STATUS) || (paddr == `REG_LAST_CRC);
   assign pready    = 1'b1;
   assign pslverr   = access & ~addr_ok;
   assign start_req = access & pwrite & (paddr == `REG_CTRL) & pwdata[`CTRL_START_BIT];

   // Read mux; status shows busy, active group count and packet count
   always @* begin
      next_prdata = 32'h0000_0000;
      if (field_hit)
         next_prdata = {16'h0000, field_sel[field_idx]};
      else if (paddr == `REG_CTRL)
         next_prdata = {31'h0000_0000, frame_busy};
      else if (paddr == `REG_GROUP_SELECT)
         next_prdata = {24'h00_0000, group_sel};
      else if (paddr == `REG_STATUS)
         next_prdata = {packet_count, 3'b000, popcount(group_sel), 1'b0, 7'h00, frame_busy};
      else if (paddr == `REG_LAST_CRC)
         next_prdata = {16'h0000, last_crc};
   end

   // Register writes and read capture
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prdata    <= 32'h0000_0000;
         group_sel <= 8'h00;
         for (i = 0; i < 6; i = i + 1)
            field_sel[i] <= 16'h0000;
      end else begin
         // Read data is taken in setup so it stands through access
         if (setup && !pwrite)
            prdata <= next_prdata;
         if (access && pwrite && paddr == `REG_GROUP_SELECT)
            group_sel <= pwdata[7:0] & `GROUP_USED_MASK;
         if (access && pwrite && field_hit) begin
            if (field_idx == 3'd0)
               field_sel[0] <= pwdata[15:0] & `COMMON_FIELD_MASK;
            else
               field_sel[field_idx] <= pwdata[15:0];
         end
      end
   end

   // Byte offered to the FIFO in each state
   always @* begin
      fifo_in_valid = 1'b0;
      fifo_in_data  = 8'h00;
      src_ready     = 1'b0;
      case (state)
         ST_SYNC: begin
            fifo_in_valid = 1'b1;
            fifo_in_data  = `SYNC_VALUE;
         end
         ST_GROUPS: begin
            fifo_in_valid = 1'b1;
            fifo_in_data  = group_live;
         end
         ST_FSEL: begin
            // Word only for active groups, low byte first
            fifo_in_valid = group_live[grp_ptr];
            fifo_in_data  = hi_phase ? cur_field[15:8] : cur_field[7:0];
         end
         ST_PAY: begin
            // Source bytes pass straight through, no padding
            fifo_in_valid = src_valid;
            fifo_in_data  = src_data;
            src_ready     = fifo_in_ready;
         end
         ST_CRC_HI: begin
            fifo_in_valid = 1'b1;
            fifo_in_data  = crc[15:8];
         end
         ST_CRC_LO: begin
            fifo_in_valid = 1'b1;
            fifo_in_data  = crc[7:0];
         end
         default: begin
            fifo_in_valid = 1'b0;
         end
      endcase
   end

   // Packet sequencer
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state        <= ST_IDLE;
         group_live   <= 8'h00;
         grp_ptr      <= 3'd0;
         fld_ptr      <= 4'd0;
         hi_phase     <= 1'b0;
         byte_left    <= 8'h00;
         crc          <= `CRC_INIT;
         last_crc     <= 16'h0000;
         packet_count <= 16'h0000;
         for (j = 0; j < 6; j = j + 1)
            field_live[j] <= 16'h0000;
      end else begin
         // CRC skips the sync byte and the CRC bytes themselves
         if (take && (state == ST_GROUPS || state == ST_FSEL || state == ST_PAY))
            crc <= crc_step(crc, fifo_in_data);
         case (state)
            ST_IDLE: begin
               // A start while busy is ignored
               if (start_req) begin
                  group_live <= group_sel & `GROUP_USED_MASK;
                  for (j = 0; j < 6; j = j + 1)
                     field_live[j] <= field_sel[j];
                  field_live[0] <= field_sel[0] & `COMMON_FIELD_MASK;
                  crc      <= `CRC_INIT;
                  grp_ptr  <= 3'd0;
                  fld_ptr  <= 4'd0;
                  hi_phase <= 1'b0;
                  state    <= ST_SYNC;
               end
            end
            ST_SYNC: begin
               if (take)
                  state <= ST_GROUPS;
            end
            ST_GROUPS: begin
               if (take)
                  state <= ST_FSEL;
            end
            ST_FSEL: begin
               // Inactive groups are skipped in one cycle each
               if (!group_live[grp_ptr] || (take && hi_phase)) begin
                  hi_phase <= 1'b0;
                  if (grp_ptr == `LAST_GROUP) begin
                     grp_ptr <= 3'd0;
                     fld_ptr <= 4'd0;
                     state   <= ST_SCAN;
                  end else begin
                     grp_ptr <= grp_ptr + 3'd1;
                  end
               end else if (take) begin
                  hi_phase <= 1'b1;
               end
            end
            ST_SCAN: begin
               // Walk groups then fields in ascending order
               if (group_live[grp_ptr] && cur_field[fld_ptr] && field_bytes != 8'h00) begin
                  byte_left <= field_bytes;
                  state     <= ST_PAY;
               end else if (last_pos) begin
                  state <= ST_CRC_HI;
               end else begin
                  grp_ptr <= step_grp;
                  fld_ptr <= step_fld;
               end
            end
            ST_PAY: begin
               if (take) begin
                  byte_left <= byte_left - 8'd1;
                  if (byte_left == 8'd1) begin
                     grp_ptr <= step_grp;
                     fld_ptr <= step_fld;
                     state   <= last_pos ? ST_CRC_HI : ST_SCAN;
                  end
               end
            end
            ST_CRC_HI: begin
               if (take)
                  state <= ST_CRC_LO;
            end
            ST_CRC_LO: begin
               if (take) begin
                  last_crc     <= crc;
                  packet_count <= packet_count + 16'd1;
                  state        <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // packet_framer

// ===== testbench/host_tables.svh
// Purpose: Check helpers shared by the host model and the bench
// Assumes: Included inside a module body after framer_defines.vh
// Notes  : Field sizes are taken from the fixed size rows
function automatic [15:0] crc_step(input [15:0] c, input [7:0] b);
   reg [15:0] r;
   begin
      r = c ^ {b, 8'h00};
      for (int k = 0; k < 8; k++) r = r[15] ? {r[14:0], 1'b0} ^ 16'h1021 : {r[14:0], 1'b0};
      crc_step = r;
   end
endfunction
function automatic [7:0] field_size(input integer g, input integer f);
   reg [127:0] row;
   begin
      case (g)
         0: row = `SIZE_GROUP1;
         1: row = `SIZE_GROUP2;
         2: row = `SIZE_GROUP3;
         3: row = `SIZE_GROUP4;
         4: row = `SIZE_GROUP5;
         5: row = `SIZE_GROUP6;
         default: row = 128'h0;
      endcase
      field_size = row[8*f +: 8];
   end
endfunction

// ===== testbench/host_parser.sv
// Purpose: Host parser model that drains and checks the byte stream
// Assumes: One byte per handshake, packets follow one another
// Notes  : Length comes from the selects only, as a real host must work it out
`timescale 1ns/100ps
`include "framer_defines.vh"
module host_parser (
   input  wire       mclk,
   input  wire       resetn,
   input  wire [7:0] tx_data,
   input  wire       tx_valid,
   input  wire       slow,
   output reg        tx_ready,
   output reg  [7:0] got_data,
   output reg        got_stb,
   output reg        pkt_ok,
   output reg        pkt_bad
);
`include "host_tables.svh"
   reg [15:0] words [0:7]; // Field words in arrival order
   reg [7:0]  grp;         // Group byte of the packet in flight
   reg [15:0] crc;         // Running check value
   integer    idx, total, n, w;
   // Stall at random when slow, so the FIFO backs up and the source is refused
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tx_ready <= 1'b0;
         got_stb <= 1'b0;
         pkt_ok <= 1'b0;
         pkt_bad <= 1'b0;
         idx = 0;
      end else begin
         tx_ready <= slow ? ($urandom % 4 == 0) : 1'b1;
         got_stb <= tx_valid & tx_ready;
         got_data <= tx_data;
         pkt_ok <= 1'b0;
         pkt_bad <= 1'b0;
         if (tx_valid && tx_ready) begin
            if (idx == 0) begin
               pkt_bad <= (tx_data != `SYNC_VALUE);
               idx = (tx_data == `SYNC_VALUE) ? 1 : 0;
            end else begin
               crc = (idx == 1) ? crc_step(16'h0000, tx_data) : crc_step(crc, tx_data);
               if (idx == 1) begin
                  grp = tx_data;
                  n = 2 + 2 * $countones(tx_data);
                  total = n + 2;
               end else if (idx < n) begin
                  if (idx % 2 == 0) words[(idx-2)/2][7:0] = tx_data;
                  else words[(idx-2)/2][15:8] = tx_data;
               end
               if (idx == n - 1) begin
                  w = 0;
                  for (int g = 0; g < 8; g++) if (grp[g]) begin
                     for (int f = 0; f < 16; f++) if (words[w][f]) total = total + field_size(g, f);
                     w = w + 1;
                  end
               end
               if (idx == total - 1) begin
                  pkt_ok <= (crc == 16'h0000);
                  pkt_bad <= (crc != 16'h0000);
                  idx = 0;
               end else begin
                  idx = idx + 1;
               end
            end
         end
      end
   end
endmodule // host_parser

// ===== testbench/packet_framer_assertions.sv
// Purpose: Port-level checks for the packet framer
// Assumes: Sees only the framer top ports
// Notes  : Start is tracked only from an idle, drained stream
`timescale 1ns/100ps
`include "framer_defines.vh"
module packet_framer_assertions (
   input wire                   mclk,
   input wire                   resetn,
   input wire [`APB_ADDR_W-1:0] paddr,
   input wire                   psel,
   input wire                   penable,
   input wire                   pwrite,
   input wire [31:0]            pwdata,
   input wire [31:0]            prdata,
   input wire                   pready,
   input wire                   pslverr,
   input wire                   src_ready,
   input wire [7:0]             tx_data,
   input wire                   tx_valid,
   input wire                   tx_ready,
   input wire                   frame_busy
);
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!resetn);
   wire mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h24); // Decoded register window
   wire start_ok = psel && penable && pwrite && (paddr == `REG_CTRL) && pwdata[0] && !frame_busy && !tx_valid;
   wire tx_take = tx_valid && tx_ready;
   reg [1:0] lead; // Bytes of a fresh packet handed over, saturates at 2
   // Saturation keeps the count harmless while no start has been seen
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) lead <= 2'h2;
      else if (start_ok) lead <= 2'h0;
      else if (tx_take && lead != 2'h2) lead <= lead + 2'h1;
   end
   sequence start_req; start_ok; endsequence
   sequence bad_read; psel && !penable && !pwrite && !mapped; endsequence
   pready_const_a: assert property (pready) else $error("pready low");
   err_map_a: assert property (psel && penable |-> pslverr == !mapped) else $error("pslverr wrong");
   rd_zero_a: assert property (bad_read |=> prdata == 32'h0) else $error("unmapped read not zero");
   busy_start_a: assert property (start_req |=> frame_busy [*2]) else $error("busy missing");
   hdr_first_a: assert property (start_req |=> !src_ready [*2]) else $error("payload before header");
   src_gate_a: assert property (src_ready |-> frame_busy) else $error("source taken while idle");
   sync_first_a: assert property (tx_take && lead == 2'h0 |-> tx_data == `SYNC_VALUE) else $error("no sync");
   group_rsv_a: assert property (tx_take && lead == 2'h1 |-> tx_data[7:6] == 2'h0) else $error("group bits");
   tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("byte lost");
endmodule // packet_framer_assertions
bind packet_framer packet_framer_assertions u_packet_framer_assertions (.mclk(mclk), .resetn(resetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .src_ready(src_ready), .tx_data(tx_data), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .frame_busy(frame_busy));

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the packet framer
// Assumes: Host model drains the stream and rechecks each packet
// Notes  : Expected bytes are built in queues before each start
`timescale 1ns/100ps
`include "framer_defines.vh"
module tb;
`include "host_tables.svh"
   reg         mclk = 1'b0;
   reg         resetn = 1'b0;
   reg  [7:0]  paddr = 8'h00;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [31:0] pwdata = 32'h0;
   reg  [7:0]  src_data = 8'h00;
   reg         src_valid = 1'b0;
   reg         slow = 1'b0;
   wire [31:0] prdata;
   wire [7:0]  tx_data, got_data;
   wire        pready, pslverr, src_ready, tx_valid, tx_ready, frame_busy, got_stb, pkt_ok, pkt_bad;
   integer     fails = 0, samples_checked = 0, cycles = 0, oks = 0, bads = 0, pkts = 0;
   logic [7:0] srcq[$], expq[$], rxq[$]; // Source bytes, expected and received stream
   reg  [31:0] rd;                        // Last read data
   reg         err;                       // Last error response
   always #2.5 mclk = ~mclk;
   packet_framer #(.FIFO_DEPTH(4), .FIFO_PTR_W(2)) u_packet_framer (.mclk(mclk), .resetn(resetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .frame_busy(frame_busy));
   host_parser u_host_parser (.mclk(mclk), .resetn(resetn), .tx_data(tx_data), .tx_valid(tx_valid),
      .slow(slow), .tx_ready(tx_ready), .got_data(got_data), .got_stb(got_stb), .pkt_ok(pkt_ok), .pkt_bad(pkt_bad));
   // Collect accepted bytes and cut a hang short
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (got_stb) rxq.push_back(got_data);
      if (pkt_ok) oks <= oks + 1;
      if (pkt_bad) bads <= bads + 1;
      if (cycles == 80000) begin
         fails = fails + 1;
         report_and_stop;
      end
   end
   // Offer payload with random gaps; an offer stands until taken
   always @(posedge mclk) begin
      if (src_valid && src_ready) void'(srcq.pop_front());
      if (!src_valid || src_ready) begin
         src_valid <= (srcq.size() > 0) && ($urandom % 4 != 0);
         src_data <= (srcq.size() > 0) ? srcq[0] : 8'($urandom);
      end
   end
   task automatic check(input [31:0] seen, input [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer, entered just after a rising edge
   task automatic apb(input [7:0] a, input w, input [31:0] d);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   // Set up, start, and compare one whole packet
   task automatic packet(input [7:0] gsel, input [95:0] fl);
      logic [15:0] fw [0:5];
      logic [7:0]  g, b;
      logic [15:0] crc;
      g = gsel & `GROUP_USED_MASK;
      apb(`REG_GROUP_SELECT, 1, {24'h0, gsel});
      apb(`REG_GROUP_SELECT, 0, 0);
      check(rd, {24'h0, g});
      for (int i = 0; i < 6; i++) begin
         fw[i] = fl[16*i +: 16] & ((i == 0) ? `COMMON_FIELD_MASK : 16'hFFFF);
         apb(8'(`REG_FIELD_BASE + 4*i), 1, {16'h0, fl[16*i +: 16]});
      end
      apb(`REG_FIELD_BASE, 0, 0);
      check(rd, {16'h0, fw[0]});
      crc = crc_step(16'h0000, g);
      expq = '{`SYNC_VALUE, g};
      for (int i = 0; i < 6; i++) if (g[i]) begin
         expq.push_back(fw[i][7:0]);
         expq.push_back(fw[i][15:8]);
         crc = crc_step(crc_step(crc, fw[i][7:0]), fw[i][15:8]);
      end
      for (int i = 0; i < 6; i++) for (int f = 0; f < 16; f++) if (g[i] && fw[i][f]) repeat (field_size(i, f)) begin
         b = 8'($urandom);
         srcq.push_back(b);
         expq.push_back(b);
         crc = crc_step(crc, b);
      end
      expq.push_back(crc[15:8]);
      expq.push_back(crc[7:0]);
      rxq.delete();
      slow <= gsel[0];
      apb(`REG_CTRL, 1, 1);
      apb(`REG_CTRL, 1, 1);
      pkts = pkts + 1;
      while (frame_busy !== 1'b0 || tx_valid !== 1'b0) @(posedge mclk);
      repeat (3) @(posedge mclk);
      check(rxq.size(), expq.size());
      for (int i = 0; i < expq.size(); i++) check((i < rxq.size()) ? rxq[i] : 32'h100, expq[i]);
      apb(`REG_STATUS, 0, 0);
      check(rd, {pkts[15:0], 3'h0, 4'($countones(g)), 9'h000});
      apb(`REG_LAST_CRC, 0, 0);
      check(rd, {16'h0, crc});
      check(oks, pkts);
      check(bads, 0);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Reset, register decode, then packets from plain to awkward
   initial begin
      void'($urandom(32'h223DEAC6));
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      for (int a = 0; a < 'h2C; a += 2) begin
         apb(8'(a), 0, 0);
         check(err, (a % 4 != 0) || (a > 'h24));
         check(rd, 0);
      end
      apb(8'h30, 1, 32'hFFFFFFFF);
      check(err, 1);
      packet(8'h01, 96'h0008);
      packet(8'h05, 96'h0001_0000_0008);
      packet(8'h00, {96{1'b1}});
      packet(8'h02, 96'hFF00_0000);
      packet(8'hFF, {96{1'b1}});
      repeat (4) packet(8'($urandom), {$urandom, $urandom, $urandom});
      report_and_stop;
   end
endmodule // tb
